// [iws_core.sv]
// two-wire slave with clock-stretch wait handling and event status.
// assumes scl/sda arrive unsynchronised from open-drain pads and that the
// register master follows the one-cycle strobe protocol.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - a device not ready for the next byte holds the clock line low.
// - no new byte transfer until both ends release the clock line.
// - wait is inserted automatically; wait timing select picks 8th or 9th clock.
// - wait ends on wait release bit set or all-ones write to shift register.
// - transmitter writing next byte to shift register releases wait and shifts it.
// - setting start or stop trigger also releases a pending wait.
// - addressed slave interrupts after address with 0001X110, after data 0001X000, or 0001X100 for an acked byte interrupting on the 9th clock.
// - after stop, interrupt with 00000001 only when stop interrupt enabled.
// - restart plus matching address repeats address interrupt, then data interrupts.
// - stop sets stop seen flag; interrupt only if stop interrupt enable set.
// - start condition sets the start seen flag.
// - direction bit after address updates transmit role flag; zero means receive.
module iws_core (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire iws_pkg::iws_addr_t reg_addr,
    input  wire iws_pkg::iws_byte_t reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output iws_pkg::iws_byte_t     reg_rdata,
    input  wire logic              scl_in,
    output logic                   scl_out,
    output logic                   scl_oe,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe,
    output logic                   bus_event_irq
);
    import iws_pkg::*;

    logic       scl_s1_reg;
    logic       scl_s2_reg;
    logic       scl_d_reg;
    logic       sda_s1_reg;
    logic       sda_s2_reg;
    logic       sda_d_reg;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    iws_byte_t  bus_control_reg;
    iws_byte_t  own_address_reg;
    iws_byte_t  rx_shift_reg;
    iws_byte_t  tx_shift_reg;
    iws_byte_t  rdata_reg;
    iws_phase_e phase_reg;
    logic [3:0] bit_cnt_reg;
    logic       wait_reg;
    logic       pend_reg;
    logic       first_reg;
    logic       irq_reg;
    logic       scl_oe_reg;
    logic       sda_oe_reg;
    logic       stop_seen_flag;
    logic       start_seen_flag;
    logic       ack_seen_reg;
    logic       transmit_role_flag;
    logic       addressed_reg;

    logic       wr_ctl;
    logic       wr_shift;
    logic       wr_own;
    logic       rd_shift;
    logic       release_evt;
    logic       ev_ack_slot;
    logic       ev_last;
    logic       addr_match;
    logic       wait_set;
    logic       irq_set;
    logic       sda_oe_next;
    logic       enabled;
    iws_byte_t  status_byte;
    iws_byte_s  buf_in;
    iws_byte_s  buf_out;
    logic       buf_in_ready;
    logic       buf_out_valid;

    // pin synchronisers; the third stage only feeds edge detection
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg  <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg  <= 1'b1;
        end
        else
        begin
            scl_s1_reg <= scl_in;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg  <= scl_s2_reg;
            sda_s1_reg <= sda_in;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg  <= sda_s2_reg;
        end
    end

    // bits only advance on real line edges, so a stretched clock stalls the byte
    assign scl_rise  = scl_s2_reg && !scl_d_reg;
    assign scl_fall  = !scl_s2_reg && scl_d_reg;
    assign start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
    assign stop_det  = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;
    assign enabled   = bus_control_reg[CTL_ENABLE];

    assign wr_ctl   = reg_wr && (reg_addr == OFF_CTL);
    assign wr_shift = reg_wr && (reg_addr == OFF_SHIFT);
    assign wr_own   = reg_wr && (reg_addr == OFF_OWN);
    assign rd_shift = reg_rd && (reg_addr == OFF_SHIFT);

    assign release_evt = (wr_ctl && reg_wdata[CTL_WAIT_REL])
                      || (wr_shift && reg_wdata == RELEASE_BYTE)
                      || (wr_shift && transmit_role_flag)
                      || (wr_ctl && (reg_wdata[CTL_START_TRIG] || reg_wdata[CTL_STOP_TRIG]));

    assign ev_ack_slot = scl_fall && bit_cnt_reg == BIT_ACK_SLOT;
    assign ev_last     = scl_fall && bit_cnt_reg == BIT_LAST;
    assign addr_match  = (rx_shift_reg & OWN_MASK) == (own_address_reg & OWN_MASK);

    // wait points: after address ack, 8th or 9th clock of a data byte
    always_comb
    begin
        wait_set = 1'b0;
        irq_set  = 1'b0;
        if (phase_reg == PH_ADDR && ev_last && addressed_reg)
        begin
            wait_set = 1'b1;
            irq_set  = 1'b1;
        end
        else if (phase_reg == PH_DATA && !transmit_role_flag)
        begin
            if (ev_ack_slot && !bus_control_reg[CTL_WAIT_TIME])
            begin
                wait_set = 1'b1;
                irq_set  = 1'b1;
            end
            else if (ev_last && bus_control_reg[CTL_WAIT_TIME])
            begin
                wait_set = 1'b1;
                irq_set  = 1'b1;
            end
        end
        else if (phase_reg == PH_DATA && ev_last)
        begin
            wait_set = ack_seen_reg;
            irq_set  = 1'b1;
        end
        if (stop_det && bus_control_reg[CTL_STOP_IRQ])
            irq_set = 1'b1;
    end

    // byte framing and phase
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_reg    <= PH_IDLE;
            bit_cnt_reg  <= 4'h0;
            rx_shift_reg <= SHIFT_RESET;
        end
        else if (start_det && enabled)
        begin
            phase_reg   <= PH_ADDR;
            bit_cnt_reg <= 4'h0;
        end
        else if (stop_det)
        begin
            phase_reg   <= PH_IDLE;
            bit_cnt_reg <= 4'h0;
        end
        else
        begin
            if (scl_rise && bit_cnt_reg < BIT_ACK_SLOT)
                rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
            if (scl_rise)
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            else if (ev_last)
                bit_cnt_reg <= 4'h0;
            if (phase_reg == PH_ADDR && ev_ack_slot && !addr_match)
                phase_reg <= PH_HOLD;
            else if (phase_reg == PH_ADDR && ev_last)
                phase_reg <= PH_DATA;
            else if (phase_reg == PH_DATA && transmit_role_flag && ev_last && !ack_seen_reg)
                phase_reg <= PH_HOLD;
        end
    end

    // status flags; hardware sets, stop/start events clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stop_seen_flag     <= 1'b0;
            start_seen_flag    <= 1'b0;
            ack_seen_reg       <= 1'b0;
            transmit_role_flag <= 1'b0;
            addressed_reg      <= 1'b0;
        end
        else if (start_det && enabled)
        begin
            start_seen_flag    <= 1'b1;
            stop_seen_flag     <= 1'b0;
            ack_seen_reg       <= 1'b0;
            transmit_role_flag <= 1'b0;
            addressed_reg      <= 1'b0;
        end
        else if (stop_det)
        begin
            stop_seen_flag     <= 1'b1;
            start_seen_flag    <= 1'b0;
            ack_seen_reg       <= 1'b0;
            transmit_role_flag <= 1'b0;
            addressed_reg      <= 1'b0;
        end
        else
        begin
            if (scl_rise && bit_cnt_reg == BIT_ACK_SLOT)
                ack_seen_reg <= !sda_s2_reg;
            else if (ev_ack_slot)
                ack_seen_reg <= 1'b0;
            if (phase_reg == PH_ADDR && ev_ack_slot && addr_match)
            begin
                addressed_reg      <= 1'b1;
                transmit_role_flag <= rx_shift_reg[0];
            end
            if (phase_reg == PH_DATA && irq_set)
                start_seen_flag <= 1'b0;
        end
    end

    // wait holds until a release action; a new wait point wins over a release
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            wait_reg <= 1'b0;
        else if (start_det || stop_det)
            wait_reg <= 1'b0;
        else if (wait_set)
            wait_reg <= 1'b1;
        else if (release_evt)
            wait_reg <= 1'b0;
    end

    // a received byte waits here while the buffer is full, stretching scl
    assign buf_in.data  = rx_shift_reg;
    assign buf_in.first = first_reg;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pend_reg  <= 1'b0;
            first_reg <= 1'b0;
        end
        else
        begin
            if (phase_reg == PH_DATA && !transmit_role_flag && ev_ack_slot)
                pend_reg <= 1'b1;
            else if (buf_in_ready)
                pend_reg <= 1'b0;
            if (phase_reg == PH_ADDR && ev_last)
                first_reg <= 1'b1;
            else if (pend_reg && buf_in_ready)
                first_reg <= 1'b0;
        end
    end

    iws_buf u_rx_buf (
        .clock     (clock),
        .rst_b     (rst_b),
        .in_valid  (pend_reg),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in),
        .out_valid (buf_out_valid),
        .out_ready (rd_shift),
        .out_data  (buf_out)
    );

    // transmit shifter; first bit appears as soon as the wait is released
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            tx_shift_reg <= SHIFT_RESET;
        else if (wr_shift)
            tx_shift_reg <= reg_wdata;
        else if (scl_fall && transmit_role_flag && phase_reg == PH_DATA
                 && bit_cnt_reg != 4'h0 && bit_cnt_reg < BIT_ACK_SLOT)
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
    end

    always_comb
    begin
        sda_oe_next = 1'b0;
        if (bit_cnt_reg == BIT_ACK_SLOT)
            sda_oe_next = (phase_reg == PH_ADDR && addressed_reg)
                       || (phase_reg == PH_DATA && !transmit_role_flag && bus_control_reg[CTL_ACK_EN]);
        else if (phase_reg == PH_DATA && transmit_role_flag && bit_cnt_reg < BIT_ACK_SLOT && !wait_reg)
            sda_oe_next = !tx_shift_reg[7];
    end

    // registers
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_control_reg <= CTL_RESET;
            own_address_reg <= OWN_RESET;
        end
        else
        begin
            if (wr_ctl)
                bus_control_reg <= reg_wdata & CTL_STORE_MASK;
            if (wr_own)
                own_address_reg <= reg_wdata & OWN_MASK;
        end
    end

    assign status_byte = {3'h0, addressed_reg, transmit_role_flag, ack_seen_reg, start_seen_flag, stop_seen_flag};

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rdata_reg <= 8'h00;
        else if (reg_rd)
        begin
            case (reg_addr)
                OFF_CTL:    rdata_reg <= bus_control_reg;
                OFF_STATUS: rdata_reg <= status_byte;
                OFF_SHIFT:  rdata_reg <= buf_out_valid ? buf_out.data : rx_shift_reg;
                OFF_OWN:    rdata_reg <= own_address_reg;
                default:    rdata_reg <= 8'h00;
            endcase
        end
    end

    // pin drivers and event pulse, all registered
    // sda only moves while scl is seen low: a move under a high scl reads as start or stop
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            irq_reg    <= 1'b0;
        end
        else
        begin
            scl_oe_reg <= wait_reg || pend_reg;
            if (!scl_s2_reg)
                sda_oe_reg <= sda_oe_next;
            irq_reg    <= irq_set;
        end
    end

    assign scl_out       = 1'b0;
    assign sda_out       = 1'b0;
    assign scl_oe        = scl_oe_reg;
    assign sda_oe        = sda_oe_reg;
    assign bus_event_irq = irq_reg;
    assign reg_rdata     = rdata_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_wait_holds_scl: assert property (wait_reg |=> scl_oe)
        else $error("wait pending but scl not held low");
    a_rel_bit_frees: assert property (wr_ctl && reg_wdata[CTL_WAIT_REL] && !wait_set |=> !wait_reg)
        else $error("wait release bit did not end wait");
    a_ff_write_frees: assert property (wr_shift && reg_wdata == RELEASE_BYTE && !wait_set
                                       |=> !wait_reg ##1 (!scl_oe || $past(pend_reg)))
        else $error("all-ones write did not end wait");
    a_trig_frees: assert property (wr_ctl && (reg_wdata[CTL_STOP_TRIG] || reg_wdata[CTL_START_TRIG]) && !wait_set
                                   |=> !wait_reg)
        else $error("start or stop trigger did not end wait");
    a_stop_sets_flag: assert property (stop_det |=> stop_seen_flag && !start_seen_flag)
        else $error("stop not recorded");
    a_stop_irq_gated: assert property (stop_det && !bus_control_reg[CTL_STOP_IRQ] && !irq_set |=> !bus_event_irq)
        else $error("stop interrupt without enable");
    a_start_sets_flag: assert property (start_det && enabled |=> start_seen_flag ##0 !stop_seen_flag)
        else $error("start not recorded");
    a_addr_status: assert property (bus_event_irq && start_seen_flag |-> status_byte[2:0] == 3'b110 && addressed_reg)
        else $error("address interrupt status wrong");
    a_data_status: assert property (bus_event_irq && !stop_seen_flag && !start_seen_flag |-> addressed_reg)
        else $error("data interrupt while not addressed");
    a_role_update: assert property (phase_reg == PH_ADDR && ev_ack_slot && addr_match && !start_det && !stop_det
                                    |=> transmit_role_flag == $past(rx_shift_reg[0]))
        else $error("transmit role not taken from direction bit");
endmodule

`default_nettype wire

// [iws_buf.sv]
// package of constants and types for the two-wire wait/status block,
// plus the two-entry receive buffer that sits in the received-byte path.
// assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none

package iws_pkg;
    typedef logic [1:0] iws_addr_t;
    typedef logic [7:0] iws_byte_t;

    // register offsets on the plain register port
    localparam iws_addr_t OFF_CTL    = 2'h0;
    localparam iws_addr_t OFF_STATUS = 2'h1;
    localparam iws_addr_t OFF_SHIFT  = 2'h2;
    localparam iws_addr_t OFF_OWN    = 2'h3;

    // bus_control_reg fields
    localparam int CTL_STOP_TRIG  = 0;
    localparam int CTL_START_TRIG = 1;
    localparam int CTL_ACK_EN     = 2;
    localparam int CTL_WAIT_TIME  = 3;
    localparam int CTL_STOP_IRQ   = 4;
    localparam int CTL_WAIT_REL   = 5;
    localparam int CTL_ENABLE     = 7;
    localparam iws_byte_t CTL_STORE_MASK = 8'h9C;
    localparam iws_byte_t CTL_RESET      = 8'h00;

    // status_byte fields
    localparam int ST_STOP  = 0;
    localparam int ST_START = 1;
    localparam int ST_ACK   = 2;
    localparam int ST_TRC   = 3;
    localparam int ST_ADDR  = 4;

    localparam iws_byte_t SHIFT_RESET   = 8'h00;
    localparam iws_byte_t OWN_RESET     = 8'h00;
    localparam iws_byte_t OWN_MASK      = 8'hFE;
    localparam iws_byte_t RELEASE_BYTE  = 8'hFF;
    localparam logic [3:0] BIT_ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_LAST     = 4'h9;

    typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_HOLD} iws_phase_e;

    typedef struct packed {
        iws_byte_t data;
        logic      first;
    } iws_byte_s;
endpackage

module iws_buf (
    input  wire logic               clock,
    input  wire logic               rst_b,
    input  wire logic               in_valid,
    output logic                    in_ready,
    input  wire iws_pkg::iws_byte_s in_data,
    output logic                    out_valid,
    input  wire logic               out_ready,
    output iws_pkg::iws_byte_s      out_data
);
    import iws_pkg::*;

    iws_byte_s  mem_reg [2];
    logic       wptr_reg;
    logic       rptr_reg;
    logic [1:0] count_reg;
    logic       push;
    logic       pop;

    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_ready && out_valid;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end
        else if (push)
        begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wptr_reg  <= 1'b0;
            rptr_reg  <= 1'b0;
            count_reg <= 2'h0;
        end
        else
        begin
            if (push)
                wptr_reg <= ~wptr_reg;
            if (pop)
                rptr_reg <= ~rptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

`default_nettype wire

// [iws_master_model.sv]
// behavioural two-wire bus master facing the slave across the link.
// assumes the bench resolves both open-drain lines with pull-ups.
`timescale 1ns/10ps
`default_nettype none
module iws_master_model (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_pull,
    output logic      sda_pull
);
    // 2*LOW + HIGH gives the 160 ns link period
    localparam time LOW  = 60ns;
    localparam time HIGH = 40ns;

    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // a stretched clock simply blocks here; the bench watchdog bounds it
    task automatic let_scl_rise();
        scl_pull = 1'b0;
        wait (scl === 1'b1);
    endtask

    task automatic start_cond();
        #7;
        sda_pull = 1'b0;
        wait (sda === 1'b1);
        #LOW;
        let_scl_rise();
        #LOW;
        sda_pull = 1'b1;
        #LOW;
        scl_pull = 1'b1;
    endtask

    task automatic stop_cond();
        #LOW;
        sda_pull = 1'b1;
        #LOW;
        let_scl_rise();
        #LOW;
        sda_pull = 1'b0;
        #LOW;
    endtask

    // nine clocks; own marks bits this end drives, the rest are sampled
    task automatic xfer(input logic [8:0] tx, input logic [8:0] own, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            #LOW;
            sda_pull = own[i] & ~tx[i];
            if (own[i])
                wait (sda === tx[i]);
            #LOW;
            let_scl_rise();
            #HIGH;
            rx[i] = sda;
            scl_pull = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// [tb_i2c_wait_and_status_events.sv]
// self-checking bench for the two-wire slave wait and status logic.
// assumes iws_core on top and iws_master_model on the far side.
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_wait_and_status_events;
    import iws_pkg::*;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    iws_addr_t   reg_addr = OFF_CTL;
    iws_byte_t   reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    iws_byte_t   reg_rdata;
    logic        scl_oe;
    logic        sda_oe;
    logic        bus_event_irq;
    logic        m_scl;
    logic        m_sda;
    wire logic   scl = ~(m_scl | scl_oe);
    wire logic   sda = ~(m_sda | sda_oe);
    logic        rd_q = 1'b0;
    iws_byte_t   exp_q[$];
    int          n_irq = 0;
    int          n_seen = 0;
    int          n_mismatch = 0;
    int          n_compared = 0;
    logic [16:0] seed = 17'h151A8;
    iws_byte_t   ctl = 8'h00;
    logic [8:0]  rx;

    always #10 clock = ~clock;

    iws_core dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .bus_event_irq(bus_event_irq));
    iws_master_model m (.scl(scl), .sda(sda), .scl_pull(m_scl), .sda_pull(m_sda));

    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction

    task automatic chk(input string nm, input iws_byte_t e, input iws_byte_t g);
        n_compared++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // read data stand from the cycle after the strobe until the next read
    always @(posedge clock)
    begin
        if (rd_q)
            chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        rd_q <= reg_rd;
        if (bus_event_irq === 1'b1)
            n_irq++;
    end

    task automatic wr(input iws_addr_t a, input iws_byte_t d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input iws_addr_t a, input iws_byte_t e);
        @(posedge clock);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
    endtask

    task automatic irq_stat(input iws_byte_t st);
        int n0;
        n0 = n_irq;
        for (int i = 0; i < 600 && n_irq == n0; i++)
            @(posedge clock);
        chk("irq count", 8'h01, 8'(n_irq - n0));
        rd(OFF_STATUS, st);
    endtask

    task automatic wait_point(input iws_byte_t st, input iws_byte_t d, input int k);
        irq_stat(st);
        rd(OFF_SHIFT, d);
        #1;
        chk("scl_oe held", 8'h01, {7'h00, scl_oe});
        case (k)
            0: wr(OFF_CTL, ctl | 8'h20);
            1: wr(OFF_SHIFT, RELEASE_BYTE);
            2: wr(OFF_CTL, ctl | 8'h02);
            // last release also drops ack enable, so an 8th-clock wait byte goes unacked
            default: wr(OFF_CTL, (ctl & 8'hFB) | 8'h01);
        endcase
        repeat (3) @(posedge clock);
        #1;
        chk("scl_oe freed", 8'h00, {7'h00, scl_oe});
    endtask

    initial
    begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        for (int a = 0; a < 4; a++)
            rd(iws_addr_t'(a), 8'h00);
        wr(OFF_OWN, 8'hA1);
        rd(OFF_OWN, 8'hA0);
        wr(OFF_CTL, 8'hFF);
        rd(OFF_CTL, 8'h9C);
        $display("test registers done");
        for (int wt = 0; wt < 2; wt++)
        begin
            ctl = 8'h94 | 8'(wt << 3);
            wr(OFF_CTL, ctl);
            m.start_cond();
            m.xfer({8'hA0, 1'b1}, 9'h1FE, rx);
            chk("addr ack", 8'h00, {7'h00, rx[0]});
            wait_point(8'h16, 8'hA0, 0);
            for (int k = 0; k < 4; k++)
            begin
                if (k == 2)
                begin
                    m.start_cond();
                    m.xfer({8'hA0, 1'b1}, 9'h1FE, rx);
                    wait_point(8'h16, 8'hA0, 1);
                end
                seed = lfsr(seed);
                fork
                    m.xfer({seed[7:0], 1'b1}, 9'h1FE, rx);
                    if (wt == 0)
                        wait_point(8'h10, seed[7:0], k);
                join
                if (wt == 1)
                    wait_point(8'h14, seed[7:0], k);
                chk("data ack", {7'h00, wt == 0 && k == 3}, {7'h00, rx[0]});
            end
            m.stop_cond();
            irq_stat(8'h01);
            $display("test receive %0d done", wt);
        end
        ctl = 8'h84;
        wr(OFF_CTL, ctl);
        n_seen = n_irq;
        m.start_cond();
        m.xfer({8'h52, 1'b1}, 9'h1FE, rx);
        chk("foreign ack", 8'h01, {7'h00, rx[0]});
        m.stop_cond();
        repeat (20) @(posedge clock);
        chk("quiet irq", 8'h00, 8'(n_irq - n_seen));
        rd(OFF_STATUS, 8'h01);
        $display("test foreign address done");
        ctl = 8'h94;
        wr(OFF_CTL, ctl);
        m.start_cond();
        m.xfer({8'hA1, 1'b1}, 9'h1FE, rx);
        irq_stat(8'h1E);
        seed = lfsr(seed);
        wr(OFF_SHIFT, seed[7:0]);
        m.xfer(9'h1FF, 9'h001, rx);
        chk("sent byte", seed[7:0], rx[8:1]);
        irq_stat(8'h18);
        m.stop_cond();
        irq_stat(8'h01);
        $display("test transmit done");
        end_of_test();
    end

    // a whole run needs well under 100 us of link traffic
    initial
    begin
        #300us;
        $display("watchdog expired");
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
